// ===== pkg/gifm_pkg.sv
package gifm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_GPI_MAX = 32;
  localparam int NUM_PINS_DEF = 84;
  localparam int NUM_LOGIC_OUT_DEF = 16;
  localparam int NUM_STATE_SEL = 3;
  localparam int ADDR_W = 8;
  localparam int MAP_W = 7;
  localparam int IDX_W = 5;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_POLARITY = 8'h00;
  localparam logic [7:0] OFF_DEFINED = 8'h04;
  localparam logic [7:0] OFF_FAULT_EN = 8'h08;
  localparam logic [7:0] OFF_CLEAR_SRC = 8'h0C;
  localparam logic [7:0] OFF_FAULTBUS_EN = 8'h10;
  localparam logic [7:0] OFF_FUNC_SEL = 8'h14;
  localparam logic [7:0] OFF_SEQ_ON_DEP = 8'h18;
  localparam logic [7:0] OFF_SEQ_OFF_DEP = 8'h1C;
  localparam logic [7:0] OFF_ASSERTED = 8'h20;
  localparam logic [7:0] OFF_IN_FAULT = 8'h24;
  localparam logic [7:0] OFF_MODE = 8'h28;
  localparam logic [7:0] OFF_PIN_MAP = 8'h80;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_POLARITY = 32'hFFFFFFFF;
  localparam logic [31:0] RST_MASK = 32'h00000000;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic [9:0] rsvd2;
    logic debug_valid;
    logic [IDX_W-1:0] debug_idx;
    logic [1:0] rsvd1;
    logic msel_valid;
    logic [IDX_W-1:0] msel_idx;
    logic [1:0] rsvd0;
    logic men_valid;
    logic [IDX_W-1:0] men_idx;
  } gifm_func_sel_type;

  typedef struct packed {
    logic [22:0] rsvd;
    logic faultbus_seen_low;
    logic faultbus_driving;
    logic [NUM_STATE_SEL-1:0] pin_state;
    logic margin_low;
    logic margin_high;
    logic margin_active;
    logic debug_mode;
  } gifm_mode_type;

endpackage

// ===== hw/gifm_top.sv
// Functional notes
// - At most 32 of the 84 pins may serve as general inputs.
// - Each general input has its own polarity, high or low asserted.
// - Any general input can be a sequencing dependency source.
// - First three defined inputs always feed pin-selected rail state.
// - With input-fault enabled, de-assertion is a fault able to shut rails.
// - Asserted latched-clear source clears latched statuses of logic outputs.
// - Single margin-enable input puts margining rails into margined state.
// - Margin-select asserted means margin low, de-asserted margin high.
// - Debug asserted blocks alert, fault responses and logging of affected events.
// - Debug never blocks communication faults.
// - Debug disregards rail-based sequence-on and sequence-off dependencies.
// - Debug turns rails on or off at timeout, ignoring timeout action.
// - Debug with zero timeout sequences rails immediately.
// - Debug keeps fault bus pins from pulling the bus low.
// - Debug reverts logic outputs depending on suppressed events.
// - Fault-bus function needs input-fault enable on that input.
// - Fault-bus pin monitors the bus, drives low on a rail fault.
// - After the fault clears the fault-bus pin stops driving.
// - Dependency met for turn-on when asserted, turn-off when de-asserted.
// - In debug, de-asserted inputs give no fault or log, other functions stay.
module gifm_top #(
  parameter int NUM_GPI = gifm_pkg::NUM_GPI_MAX,
  parameter int NUM_PINS = gifm_pkg::NUM_PINS_DEF,
  parameter int NUM_LOGIC_OUT = gifm_pkg::NUM_LOGIC_OUT_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [gifm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gifm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_GPI-1:0] faultbus_out,
  output logic [NUM_GPI-1:0] faultbus_oe,
  input wire logic rail_fault,
  input wire logic event_alert,
  input wire logic comm_alert,
  input wire logic event_fault,
  input wire logic event_log,
  input wire logic comm_log,
  input wire logic rail_dep_on_met,
  input wire logic rail_dep_off_met,
  input wire logic seq_timeout_expired,
  input wire logic seq_timeout_zero,
  input wire logic [NUM_LOGIC_OUT-1:0] logic_output_event,
  input wire logic [NUM_LOGIC_OUT-1:0] logic_output_orig,
  output logic alert_output,
  output logic fault_response,
  output logic log_request,
  output logic input_fault,
  output logic latch_clear,
  output logic gpi_dep_on_met,
  output logic gpi_dep_off_met,
  output logic rail_dep_on_eff,
  output logic rail_dep_off_eff,
  output logic seq_force_now,
  output logic margin_active,
  output logic margin_low,
  output logic margin_high,
  output logic [gifm_pkg::NUM_STATE_SEL-1:0] pin_state,
  output logic [NUM_LOGIC_OUT-1:0] logic_output
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [NUM_GPI-1:0] polarity_q, defined_q, fault_en_q, clear_src_q, faultbus_en_q;
  logic [NUM_GPI-1:0] dep_on_q, dep_off_q;
  gifm_pkg::gifm_func_sel_type func_q;
  logic [gifm_pkg::MAP_W-1:0] pin_map_q [NUM_GPI];

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, do_write, wr_hit, rd_hit;
  logic [gifm_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, wr_mask, rd_data;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [NUM_GPI-1:0] wr_keep, wr_set;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  logic [NUM_PINS-1:0] sync1_q, sync2_q, sync3_q, level_q;
  logic [NUM_GPI-1:0] gpi_level, asserted, fault_flags, fb_drive;
  logic debug, men, msel, fb_seen_low;
  logic [gifm_pkg::NUM_STATE_SEL-1:0] state_d;
  gifm_pkg::gifm_mode_type mode;
  // Edge-free filter: a pin change is taken once two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
    end
  end

  genvar gi;
  for (gi = 0; gi < NUM_GPI; gi++) begin : g_gpi
      // Out-of-range pin index reads as low rather than aliasing
      assign gpi_level[gi] = (int'(pin_map_q[gi]) < NUM_PINS) ?
                             level_q[pin_map_q[gi]] : 1'b0;
      assign asserted[gi] = defined_q[gi] & ~(gpi_level[gi] ^ polarity_q[gi]);
      assign fault_flags[gi] = defined_q[gi] & fault_en_q[gi] & ~asserted[gi];
      assign fb_drive[gi] = defined_q[gi] & faultbus_en_q[gi] & fault_en_q[gi];
    end

  assign debug = func_q.debug_valid & asserted[func_q.debug_idx];
  assign men = func_q.men_valid & asserted[func_q.men_idx];
  assign msel = func_q.msel_valid & asserted[func_q.msel_idx];
  // Bus low seen on any fault-bus input while this device is not pulling it
  assign fb_seen_low = |(fb_drive & defined_q & ~gpi_level) & ~(rail_fault & ~debug);
  // Lowest three defined inputs, in index order, form the state code
  always_comb begin
    int n;
    n = 0;
    state_d = '0;
    for (int i = 0; i < NUM_GPI; i++) begin
      if (defined_q[i] && n < gifm_pkg::NUM_STATE_SEL) begin
        state_d[n] = asserted[i];
        n = n + 1;
      end
    end
  end
  always_comb begin
    mode = '0;
    mode.debug_mode = debug;
    mode.margin_active = men;
    mode.margin_low = men & msel;
    mode.margin_high = men & ~msel;
    mode.pin_state = state_d;
    mode.faultbus_driving = |faultbus_oe;
    mode.faultbus_seen_low = fb_seen_low;
  end

  // ****************************************************************
  // Function outputs
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_output <= 1'b0;
      fault_response <= 1'b0;
      log_request <= 1'b0;
      input_fault <= 1'b0;
      rail_dep_on_eff <= 1'b0;
      rail_dep_off_eff <= 1'b0;
      seq_force_now <= 1'b0;
      logic_output <= '0;
      latch_clear <= 1'b0;
      gpi_dep_on_met <= 1'b0;
      gpi_dep_off_met <= 1'b0;
      margin_active <= 1'b0;
      margin_low <= 1'b0;
      margin_high <= 1'b0;
      pin_state <= '0;
    end else if (ce) begin
      alert_output <= (event_alert & ~debug) | comm_alert;
      fault_response <= (event_fault | (|fault_flags)) & ~debug;
      log_request <= ((event_log | (|fault_flags)) & ~debug) | comm_log;
      input_fault <= |fault_flags & ~debug;
      rail_dep_on_eff <= rail_dep_on_met | debug;
      rail_dep_off_eff <= rail_dep_off_met | debug;
      seq_force_now <= debug & (seq_timeout_expired | seq_timeout_zero);
      logic_output <= debug ? logic_output_orig : logic_output_event;
      latch_clear <= |(asserted & clear_src_q);
      gpi_dep_on_met <= &(asserted | ~dep_on_q);
      gpi_dep_off_met <= &(~asserted | ~dep_off_q);
      margin_active <= men;
      margin_low <= men & msel;
      margin_high <= men & ~msel;
      pin_state <= state_d;
    end
  end
  // Fault bus is open drain: only ever pulls low, released in debug
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faultbus_oe <= '0;
    end else if (ce) begin
      faultbus_oe <= (rail_fault & ~debug) ? fb_drive : '0;
    end
  end
  assign faultbus_out = '0;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  assign wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_keep = ~wr_mask[NUM_GPI-1:0];
  assign wr_set = wdata_q[NUM_GPI-1:0] & wr_mask[NUM_GPI-1:0];
  // Writable: aligned words up to the off-dependency mask, and the pin map
  assign wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= gifm_pkg::OFF_SEQ_OFF_DEP ||
                  (awaddr_q >= gifm_pkg::OFF_PIN_MAP &&
                   int'(awaddr_q) < int'(gifm_pkg::OFF_PIN_MAP) + 4 * NUM_GPI));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= gifm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? gifm_pkg::RESP_OKAY : gifm_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register stores; bits above NUM_GPI are dropped by the part-selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      polarity_q <= gifm_pkg::RST_POLARITY[NUM_GPI-1:0];
      defined_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      fault_en_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      clear_src_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      faultbus_en_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      dep_on_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      dep_off_q <= gifm_pkg::RST_MASK[NUM_GPI-1:0];
      func_q <= gifm_pkg::RST_MASK;
    end else if (ce && do_write) begin
      if (awaddr_q == gifm_pkg::OFF_POLARITY) begin
        polarity_q <= (polarity_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_DEFINED) begin
        defined_q <= (defined_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_FAULT_EN) begin
        fault_en_q <= (fault_en_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_CLEAR_SRC) begin
        clear_src_q <= (clear_src_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_FAULTBUS_EN) begin
        faultbus_en_q <= (faultbus_en_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_FUNC_SEL) begin
        func_q <= (func_q & ~wr_mask) | (wdata_q & wr_mask);
      end else if (awaddr_q == gifm_pkg::OFF_SEQ_ON_DEP) begin
        dep_on_q <= (dep_on_q & wr_keep) | wr_set;
      end else if (awaddr_q == gifm_pkg::OFF_SEQ_OFF_DEP) begin
        dep_off_q <= (dep_off_q & wr_keep) | wr_set;
      end
    end
  end

  // Pin map entries default to the identity mapping
  for (gi = 0; gi < NUM_GPI; gi++) begin : g_map
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_map_q[gi] <= gifm_pkg::MAP_W'(gi);
        end else if (ce && do_write && wstrb_q[0] &&
                     awaddr_q == gifm_pkg::ADDR_W'(int'(gifm_pkg::OFF_PIN_MAP) + 4 * gi)) begin
          pin_map_q[gi] <= wdata_q[gifm_pkg::MAP_W-1:0];
        end
      end
    end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr >= gifm_pkg::OFF_PIN_MAP &&
        int'(s_axi_araddr) < int'(gifm_pkg::OFF_PIN_MAP) + 4 * NUM_GPI &&
        s_axi_araddr[1:0] == 2'h0) begin
      rd_data[gifm_pkg::MAP_W-1:0] = pin_map_q[s_axi_araddr[gifm_pkg::IDX_W+1:2]];
    end else if (s_axi_araddr == gifm_pkg::OFF_POLARITY) begin
      rd_data[NUM_GPI-1:0] = polarity_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_DEFINED) begin
      rd_data[NUM_GPI-1:0] = defined_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_FAULT_EN) begin
      rd_data[NUM_GPI-1:0] = fault_en_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_CLEAR_SRC) begin
      rd_data[NUM_GPI-1:0] = clear_src_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_FAULTBUS_EN) begin
      rd_data[NUM_GPI-1:0] = faultbus_en_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_FUNC_SEL) begin
      rd_data = func_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_SEQ_ON_DEP) begin
      rd_data[NUM_GPI-1:0] = dep_on_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_SEQ_OFF_DEP) begin
      rd_data[NUM_GPI-1:0] = dep_off_q;
    end else if (s_axi_araddr == gifm_pkg::OFF_ASSERTED) begin
      rd_data[NUM_GPI-1:0] = asserted;
    end else if (s_axi_araddr == gifm_pkg::OFF_IN_FAULT) begin
      rd_data[NUM_GPI-1:0] = fault_flags;
    end else if (s_axi_araddr == gifm_pkg::OFF_MODE) begin
      rd_data = mode;
    end else begin
      rd_hit = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= gifm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_hit ? gifm_pkg::RESP_OKAY : gifm_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

// ===== verification/gifm_pin_model.sv
module gifm_pin_model #(
  parameter int FB_PIN = 5
) (
  input wire logic [83:0] level,
  input wire logic [31:0] faultbus_oe,
  output logic [83:0] pin_in,
  output logic bus_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // **************************************
  // Pin side: plain levels, one pulled-up shared fault bus
  // **************************************
  always_comb begin
    pin_in = level;
    // Pull-up gives way to any low driver, ours or a neighbour's
    pin_in[FB_PIN] = level[FB_PIN] & ~|faultbus_oe;
  end
  // Cascaded neighbour sees the bus low
  assign bus_low = ~pin_in[FB_PIN];
endmodule

// ===== verification/gifm_top_properties.sv
module gifm_top_properties #(
  parameter int NUM_GPI = 32,
  parameter int NUM_LOGIC_OUT = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [NUM_GPI-1:0] faultbus_out,
  input wire logic [NUM_GPI-1:0] faultbus_oe,
  input wire logic rail_fault,
  input wire logic comm_alert,
  input wire logic comm_log,
  input wire logic rail_dep_on_met,
  input wire logic rail_dep_off_met,
  input wire logic seq_timeout_expired,
  input wire logic seq_timeout_zero,
  input wire logic [NUM_LOGIC_OUT-1:0] logic_output_orig,
  input wire logic alert_output,
  input wire logic fault_response,
  input wire logic log_request,
  input wire logic input_fault,
  input wire logic rail_dep_on_eff,
  input wire logic rail_dep_off_eff,
  input wire logic seq_force_now,
  input wire logic margin_active,
  input wire logic margin_low,
  input wire logic margin_high,
  input wire logic [NUM_LOGIC_OUT-1:0] logic_output
);
  timeunit 1ns;
  timeprecision 1ps;
  // **************************************
  // Checks; seq_force_now doubles as a debug-mode witness
  // **************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_comm_alert; ce && comm_alert |=> alert_output; endproperty
  a_comm_alert: assert property (p_comm_alert) else $error("comm alert lost");
  property p_comm_log; ce && comm_log |=> log_request; endproperty
  a_comm_log: assert property (p_comm_log) else $error("comm log lost");
  property p_no_drive; ce && !rail_fault |=> faultbus_oe == '0; endproperty
  a_no_drive: assert property (p_no_drive) else $error("bus driven without fault");
  property p_od; faultbus_out == '0; endproperty
  a_od: assert property (p_od) else $error("fault bus value not low");
  property p_infault; input_fault |-> fault_response && log_request; endproperty
  a_infault: assert property (p_infault) else $error("input fault not acted on");
  property p_dep_on; ce && rail_dep_on_met |=> rail_dep_on_eff; endproperty
  a_dep_on: assert property (p_dep_on) else $error("on dependency dropped");
  property p_dep_off; ce && rail_dep_off_met |=> rail_dep_off_eff; endproperty
  a_dep_off: assert property (p_dep_off) else $error("off dependency dropped");
  property p_force; ce && !seq_timeout_expired && !seq_timeout_zero |=> !seq_force_now;
  endproperty
  a_force: assert property (p_force) else $error("force without timeout");
  property p_dbg_deps;
    seq_force_now |-> rail_dep_on_eff && rail_dep_off_eff && faultbus_oe == '0;
  endproperty
  a_dbg_deps: assert property (p_dbg_deps) else $error("debug deps or bus");
  property p_dbg_alert;
    seq_force_now && $past(ce) && !$past(comm_alert) |-> !alert_output && !fault_response;
  endproperty
  a_dbg_alert: assert property (p_dbg_alert) else $error("debug alert leak");
  property p_dbg_lo;
    seq_force_now && $past(ce) |-> logic_output == $past(logic_output_orig);
  endproperty
  a_dbg_lo: assert property (p_dbg_lo) else $error("debug logic output");
  property p_margin;
    margin_low || margin_high |-> margin_active && !(margin_low && margin_high);
  endproperty
  a_margin: assert property (p_margin) else $error("margin state");
endmodule
bind gifm_top gifm_top_properties #(.NUM_GPI(NUM_GPI), .NUM_LOGIC_OUT(NUM_LOGIC_OUT)) u_props (
  .aclk, .aresetn, .ce, .faultbus_out, .faultbus_oe, .rail_fault, .comm_alert, .comm_log,
  .rail_dep_on_met, .rail_dep_off_met, .seq_timeout_expired, .seq_timeout_zero,
  .logic_output_orig, .alert_output, .fault_response, .log_request, .input_fault,
  .rail_dep_on_eff, .rail_dep_off_eff, .seq_force_now, .margin_active, .margin_low,
  .margin_high, .logic_output);

// ===== verification/tb_general_input_function_mapper.sv
module tb_general_input_function_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, ce = '1, bus_low;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, pin_state;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, faultbus_out, faultbus_oe, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [83:0] pin_in, lvl = '0;
  logic rail_fault = '0, event_alert = '0, comm_alert = '0, event_fault = '0, event_log = '0;
  logic comm_log = '0, rail_dep_on_met = '0, rail_dep_off_met = '0;
  logic seq_timeout_expired = '0, seq_timeout_zero = '0;
  logic [15:0] logic_output_event = '0, logic_output_orig = 16'hA5C3, logic_output;
  logic alert_output, fault_response, log_request, input_fault, latch_clear;
  logic gpi_dep_on_met, gpi_dep_off_met, rail_dep_on_eff, rail_dep_off_eff;
  logic seq_force_now, margin_active, margin_low, margin_high;
  int fails = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  gifm_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
    .faultbus_out, .faultbus_oe, .rail_fault, .event_alert, .comm_alert, .event_fault,
    .event_log, .comm_log, .rail_dep_on_met, .rail_dep_off_met, .seq_timeout_expired,
    .seq_timeout_zero, .logic_output_event, .logic_output_orig, .alert_output,
    .fault_response, .log_request, .input_fault, .latch_clear, .gpi_dep_on_met,
    .gpi_dep_off_met, .rail_dep_on_eff, .rail_dep_off_eff, .seq_force_now, .margin_active,
    .margin_low, .margin_high, .pin_state, .logic_output);
  gifm_pin_model pm (.level(lvl), .faultbus_oe, .pin_in, .bus_low);
  // **************************************
  // Shared tasks
  // **************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Handshakes are judged at the rising edge, before that edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      r = s_axi_bresp;
      if (++n > 50) begin
        fails++;
        print_verdict();
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (++n > 50) begin
        fails++;
        print_verdict();
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  // Bus release adds one edge before the pin path of five edges
  task settle;
    repeat (7) @(posedge aclk);
  endtask
  // **************************************
  // Scenarios
  // **************************************
  task t_regs;
    rdr(gifm_pkg::OFF_POLARITY, rd, rsp);
    chk(rd, gifm_pkg::RST_POLARITY);
    rdr(8'h40, rd, rsp);
    chk({rsp, rd}, {gifm_pkg::RESP_SLVERR, 32'h0});
    wr(gifm_pkg::OFF_ASSERTED, 32'hFFFFFFFF, rsp);
    chk(rsp, gifm_pkg::RESP_SLVERR);
    $display("regs done");
  endtask
  task t_pol;
    wr(gifm_pkg::OFF_DEFINED, 32'h0000007F, rsp);
    wr(gifm_pkg::OFF_POLARITY, 32'hFFFFFFFE, rsp);
    wr(gifm_pkg::OFF_SEQ_ON_DEP, 32'h00000003, rsp);
    wr(gifm_pkg::OFF_SEQ_OFF_DEP, 32'h00000002, rsp);
    lvl[1] <= 1'h1;
    settle();
    rdr(gifm_pkg::OFF_ASSERTED, rd, rsp);
    chk(rd, 32'h00000003);
    chk(pin_state, 3'h3);
    chk({gpi_dep_on_met, gpi_dep_off_met}, 2'h2);
    lvl[1] <= 1'h0;
    settle();
    chk({gpi_dep_on_met, gpi_dep_off_met, pin_state}, 5'h09);
    $display("polarity done");
  endtask
  task t_fault;
    // Faults stay off the pin-state inputs 0..2
    wr(gifm_pkg::OFF_FAULT_EN, 32'h00000028, rsp);
    wr(gifm_pkg::OFF_CLEAR_SRC, 32'h00000004, rsp);
    wr(gifm_pkg::OFF_FAULTBUS_EN, 32'h00000060, rsp);
    lvl[5] <= 1'h1;
    settle();
    chk({input_fault, fault_response, log_request, latch_clear}, 4'hE);
    rdr(gifm_pkg::OFF_IN_FAULT, rd, rsp);
    chk(rd, 32'h00000008);
    lvl[3] <= 1'h1;
    lvl[2] <= 1'h1;
    rail_fault <= 1'h1;
    settle();
    chk(faultbus_oe, 32'h00000020);
    chk({bus_low, latch_clear}, 2'h3);
    rail_fault <= 1'h0;
    lvl[2] <= 1'h0;
    settle();
    chk({faultbus_oe, input_fault, latch_clear}, 34'h0);
    $display("fault done");
  endtask
  task t_margin;
    wr(gifm_pkg::OFF_FUNC_SEL, 32'h00002221, rsp);
    lvl[1] <= 1'h1;
    lvl[2] <= 1'h1;
    settle();
    chk({margin_active, margin_low, margin_high}, 3'h6);
    lvl[2] <= 1'h0;
    settle();
    chk({margin_active, margin_low, margin_high}, 3'h5);
    lvl[1] <= 1'h0;
    settle();
    chk({margin_active, margin_low, margin_high}, 3'h0);
    $display("margin done");
  endtask
  task t_debug;
    wr(gifm_pkg::OFF_FUNC_SEL, 32'h00242221, rsp);
    lvl[4] <= 1'h1;
    lvl[3] <= 1'h0;
    {event_alert, event_fault, event_log, rail_fault, seq_timeout_zero} <= 5'h1F;
    logic_output_event <= 16'h00F0;
    settle();
    chk({alert_output, fault_response, log_request, input_fault}, 4'h0);
    chk({rail_dep_on_eff, rail_dep_off_eff, seq_force_now}, 3'h7);
    chk(faultbus_oe, 32'h0);
    chk(logic_output, 16'hA5C3);
    chk(pin_state, 3'h1);
    {comm_alert, comm_log, seq_timeout_zero, seq_timeout_expired} <= 4'hD;
    settle();
    chk({alert_output, log_request, seq_force_now}, 3'h7);
    {comm_alert, comm_log, seq_timeout_expired} <= 3'h0;
    lvl[4] <= 1'h0;
    settle();
    chk({alert_output, fault_response, seq_force_now}, 3'h6);
    chk({faultbus_oe, logic_output}, {32'h20, 16'h00F0});
    $display("debug done");
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_pol();
    t_fault();
    t_margin();
    t_debug();
    print_verdict();
  end
endmodule
